// ==== rtl/sdrbt_regs.vh ====
`ifndef SDRBT_REGS_VH
`define SDRBT_REGS_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define SDRBT_CTRL_ADDR 12'h000
`define SDRBT_OPND_ADDR 12'h004
`define SDRBT_MEMD_ADDR 12'h008
`define SDRBT_STAT_ADDR 12'h00C
`define SDRBT_RSLT_ADDR 12'h010
`define SDRBT_ACC_ADDR 12'h014
`define SDRBT_FLAG_ADDR 12'h018
`define SDRBT_REGF_ADDR 12'h020
// ****************************************
// Control word fields
// ****************************************
`define SDRBT_CTRL_GO_BIT 0
`define SDRBT_CTRL_OP_LSB 4
`define SDRBT_CTRL_MODE_LSB 8
`define SDRBT_CTRL_REG_LSB 12
`define SDRBT_CTRL_BSEL_LSB 16
// ****************************************
// Operation codes
// ****************************************
`define SDRBT_OP_ASL 3'h0
`define SDRBT_OP_ASR 3'h1
`define SDRBT_OP_LSR 3'h2
`define SDRBT_OP_DRL 3'h3
`define SDRBT_OP_DRR 3'h4
`define SDRBT_OP_BTST 3'h5
// ****************************************
// Operand modes
// ****************************************
`define SDRBT_MODE_REG 2'h0
`define SDRBT_MODE_PTR 2'h1
`define SDRBT_MODE_IDX 2'h2
// ****************************************
// Flag bit positions
// ****************************************
`define SDRBT_F_C 0
`define SDRBT_F_N 1
`define SDRBT_F_PV 2
`define SDRBT_F_H 4
`define SDRBT_F_Z 6
`define SDRBT_F_S 7
// ****************************************
// Timing in clock states and machine cycles, accumulator code, reset flags
// ****************************************
`define SDRBT_T_REG 5'd8
`define SDRBT_T_PTR 5'd15
`define SDRBT_T_IDX 5'd23
`define SDRBT_T_DIG 5'd18
`define SDRBT_M_REG 3'd2
`define SDRBT_M_PTR 3'd4
`define SDRBT_M_IDX 3'd6
`define SDRBT_M_DIG 3'd5
`define SDRBT_ACC_CODE 3'h7
`define SDRBT_RST_FLAGS 8'h00
`endif

// ==== rtl/sdrbt_unit.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sdrbt_regs.vh"
// ****************************************
// Overview
// ****************************************
// One operation runs at a time, started from the control word
// Software preloads registers, memory byte and flags over the bus
// One clock state is one clock of clk_sys_i
// Busy stands for the whole state count of the operation
// Results, flags and write-back commit together on the last state
// Done pulses for one clock once the commit has landed
// Bus writes, a start included, are dropped while busy
// Register code 110 on a shift or bit test in register mode commits nothing and raises the bad code status
// Memory operand modes share the single memory byte holder
module sdrbt_unit
(
    // Clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    // APB slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // Status
    output wire busy_o,
    output reg done_o,
    output wire [7:0] flags_o,
    output wire [7:0] acc_o
);
    // ****************************************
    // State
    // ****************************************
    reg [7:0] regf_q [0:7]; // Register file, index 6 unused
    reg [7:0] flags_q; // Condition flags
    reg [7:0] memd_q; // Addressed memory byte
    reg [7:0] rslt_q; // Last result byte
    reg [2:0] op_q; // Latched operation
    reg [1:0] mode_q; // Latched operand mode
    reg [2:0] rsel_q; // Latched register field
    reg [2:0] bsel_q; // Latched bit select
    reg [4:0] tcnt_q; // Clock states remaining
    reg [2:0] mcyc_q; // Machine cycles of last op
    reg [4:0] tlast_q; // States of last op
    reg busy_q; // Operation running
    reg bad_reg_q; // Last op selected code 110
    // Register file mirrors the general registers by code
    // Slot six is never written, matching the missing code
    // Flags keep sign, zero, half, parity, subtract and carry slots
    // Memory byte stands in for the addressed byte in memory
    // Latched fields hold still for the whole operation
    // State counter runs down to one, then commit
    // ****************************************
    // APB decode
    // ****************************************
    // Bus strikes happen in the access phase; pready is tied high
    // Every transfer is therefore one setup plus one access clock
    // Start needs the go bit and an idle unit, so a start while busy is lost
    // Register file window covers eight word slots from its base
    // Slot six has no register behind it and reads back zero
    // Unmapped places answer with an error in the access phase
    wire wr_en = psel_i & penable_i & pwrite_i; // Write strike
    wire go = wr_en & (paddr_i == `SDRBT_CTRL_ADDR) & pwdata_i[`SDRBT_CTRL_GO_BIT] & ~busy_q;
    wire [11:0] regf_base = `SDRBT_REGF_ADDR; // Base of the register window
    wire regf_hit = (paddr_i[11:5] == regf_base[11:5]); // Register file window
    wire [2:0] regf_idx = paddr_i[4:2];
    wire mapped = regf_hit | (paddr_i == `SDRBT_CTRL_ADDR) | (paddr_i == `SDRBT_OPND_ADDR)
        | (paddr_i == `SDRBT_MEMD_ADDR) | (paddr_i == `SDRBT_STAT_ADDR) | (paddr_i == `SDRBT_RSLT_ADDR)
        | (paddr_i == `SDRBT_ACC_ADDR) | (paddr_i == `SDRBT_FLAG_ADDR);
    assign pready_o = 1'b1; // Zero wait states
    assign pslverr_o = psel_i & penable_i & ~mapped; // Unmapped access
    // Status outputs are straight copies of flip-flops
    // No glue here, so they settle right after the clock
    // Accumulator view follows register file slot seven
    assign busy_o = busy_q;
    assign flags_o = flags_q;
    assign acc_o = regf_q[`SDRBT_ACC_CODE];
    // ****************************************
    // Operand select and datapath
    // ****************************************
    wire [2:0] c_op = pwdata_i[`SDRBT_CTRL_OP_LSB +: 3];
    wire [1:0] c_mode = pwdata_i[`SDRBT_CTRL_MODE_LSB +: 2];
    wire [2:0] c_reg = pwdata_i[`SDRBT_CTRL_REG_LSB +: 3];
    wire reg_ok = (rsel_q != 3'h6); // Code 110 selects nothing
    wire [7:0] src = (mode_q == `SDRBT_MODE_REG) ? regf_q[rsel_q] : memd_q;
    wire [7:0] acc = regf_q[`SDRBT_ACC_CODE];
    reg [7:0] res; // Shift or accumulator result
    reg [7:0] mres; // Memory write-back for rotates
    reg cout; // Carry out
    reg [7:0] fnew; // Next flags
    // Datapath is purely combinational from the latched operation
    // Operand comes from the register file in register mode
    // Any memory mode takes the memory byte holder instead
    // Shifts produce result and carry out of the operand
    // Digit rotates produce a new accumulator and a write-back byte
    // Bit test produces flags and passes its operand through as the result
    // Carry defaults to the held carry, so rotates keep it
    // Flags are worked out every clock but land only at commit
    // Half-carry and subtract are cleared for every shift and rotate
    // Sign and parity follow the result, so a cleared bit 7 clears sign
    // Combinational result and flags
    always @*
    begin
        res = src;
        mres = memd_q;
        cout = flags_q[`SDRBT_F_C];
        case (op_q)
            `SDRBT_OP_ASL:
            begin
                res = {src[6:0], 1'b0};
                cout = src[7];
            end
            `SDRBT_OP_ASR:
            begin
                res = {src[7], src[7:1]};
                cout = src[0];
            end
            `SDRBT_OP_LSR:
            begin
                res = {1'b0, src[7:1]};
                cout = src[0];
            end
            `SDRBT_OP_DRL:
            begin
                mres = {memd_q[3:0], acc[3:0]};
                res = {acc[7:4], memd_q[7:4]};
            end
            `SDRBT_OP_DRR:
            begin
                mres = {acc[3:0], memd_q[7:4]};
                res = {acc[7:4], memd_q[3:0]};
            end
            default:
            begin
                res = src;
            end
        endcase
        fnew = flags_q;
        if (op_q == `SDRBT_OP_BTST)
        begin
            fnew[`SDRBT_F_Z] = ~src[bsel_q];
            fnew[`SDRBT_F_H] = 1'b1;
            fnew[`SDRBT_F_N] = 1'b0;
        end
        else
        begin
            fnew[`SDRBT_F_S] = res[7];
            fnew[`SDRBT_F_Z] = (res == 8'h00);
            fnew[`SDRBT_F_PV] = ~^res;
            fnew[`SDRBT_F_H] = 1'b0;
            fnew[`SDRBT_F_N] = 1'b0;
            fnew[`SDRBT_F_C] = cout;
        end
    end
    // ****************************************
    // Sequencer and state update
    // ****************************************
    // Start edge loads the state counter with the full state count
    // Counter steps down once per clock while busy
    // Commit happens at the edge where the counter reads one
    // So busy stands for exactly the state count of the operation
    // Done rises at that same commit edge and lasts one clock
    // Machine cycle and state counts of the last op stay readable
    // Digit rotates ignore the mode field and always use the memory byte
    // Bit test always runs the short register timing
    // Memory shifts write back to the memory byte holder
    // Register shifts write back to the selected register
    // Code 110 in register mode aborts the commit cleanly
    // Software loads only while idle, so no load meets a commit
    // Reset clears every register and the flags
    // Reset branch assigns only constants
    // Start, count states, commit at the last state
    integer k;
    always @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            for (k = 0; k < 8; k = k + 1)
                regf_q[k] <= 8'h00;
            flags_q <= `SDRBT_RST_FLAGS;
            memd_q <= 8'h00;
            rslt_q <= 8'h00;
            op_q <= 3'h0;
            mode_q <= 2'h0;
            rsel_q <= 3'h0;
            bsel_q <= 3'h0;
            tcnt_q <= 5'd0;
            mcyc_q <= 3'd0;
            tlast_q <= 5'd0;
            busy_q <= 1'b0;
            bad_reg_q <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (go)
            begin
                // Latch operation and pick its duration
                op_q <= c_op;
                mode_q <= c_mode;
                rsel_q <= c_reg;
                bsel_q <= pwdata_i[`SDRBT_CTRL_BSEL_LSB +: 3];
                busy_q <= 1'b1;
                if ((c_op == `SDRBT_OP_DRL) || (c_op == `SDRBT_OP_DRR))
                begin
                    tcnt_q <= `SDRBT_T_DIG;
                    tlast_q <= `SDRBT_T_DIG;
                    mcyc_q <= `SDRBT_M_DIG;
                end
                else if ((c_mode == `SDRBT_MODE_PTR) && (c_op != `SDRBT_OP_BTST))
                begin
                    tcnt_q <= `SDRBT_T_PTR;
                    tlast_q <= `SDRBT_T_PTR;
                    mcyc_q <= `SDRBT_M_PTR;
                end
                else if ((c_mode == `SDRBT_MODE_IDX) && (c_op != `SDRBT_OP_BTST))
                begin
                    tcnt_q <= `SDRBT_T_IDX;
                    tlast_q <= `SDRBT_T_IDX;
                    mcyc_q <= `SDRBT_M_IDX;
                end
                else
                begin
                    tcnt_q <= `SDRBT_T_REG;
                    tlast_q <= `SDRBT_T_REG;
                    mcyc_q <= `SDRBT_M_REG;
                end
            end
            else if (busy_q)
            begin
                if (tcnt_q == 5'd1)
                begin
                    // Last clock state: commit results
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                    tcnt_q <= 5'd0;
                    bad_reg_q <= 1'b0;
                    if ((op_q == `SDRBT_OP_DRL) || (op_q == `SDRBT_OP_DRR))
                    begin
                        regf_q[`SDRBT_ACC_CODE] <= res;
                        memd_q <= mres;
                        rslt_q <= res;
                        flags_q <= fnew;
                    end
                    else if ((mode_q == `SDRBT_MODE_REG) && !reg_ok)
                    begin
                        bad_reg_q <= 1'b1;
                    end
                    else
                    begin
                        flags_q <= fnew;
                        rslt_q <= res;
                        if (op_q != `SDRBT_OP_BTST)
                        begin
                            if (mode_q == `SDRBT_MODE_REG)
                                regf_q[rsel_q] <= res; // test never writes
                            else
                                memd_q <= res;
                        end
                    end
                end
                else
                begin
                    tcnt_q <= tcnt_q - 5'd1;
                end
            end
            else if (wr_en)
            begin
                // Software loads operands while idle
                if (regf_hit && (regf_idx != 3'h6))
                    regf_q[regf_idx] <= pwdata_i[7:0];
                if (paddr_i == `SDRBT_MEMD_ADDR)
                    memd_q <= pwdata_i[7:0];
                if (paddr_i == `SDRBT_FLAG_ADDR)
                    flags_q <= pwdata_i[7:0];
            end
        end
    end
    // ****************************************
    // Read data
    // ****************************************
    // Read data is captured in the setup clock of a read
    // It then stands unchanged through the access clock
    // This keeps prdata a flip-flop output with no wait state
    // Holds its value until the next read setup
    // Writes never disturb it
    // Unmapped places and the unused operand slot read zero
    // Byte wide values sit in the low byte, upper bits read zero
    // Status packs busy, bad code, machine cycles and states
    // Control readback shows the latched operation fields
    // Registered read data, captured in the read setup clock
    always @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            prdata_o <= 32'h00000000;
        else if (psel_i & ~penable_i & ~pwrite_i)
        begin
            prdata_o <= 32'h00000000;
            if (regf_hit)
                prdata_o <= {24'h000000, (regf_idx == 3'h6) ? 8'h00 : regf_q[regf_idx]};
            else if (paddr_i == `SDRBT_MEMD_ADDR)
                prdata_o <= {24'h000000, memd_q};
            else if (paddr_i == `SDRBT_STAT_ADDR)
                prdata_o <= {16'h0000, 3'h0, tlast_q, 1'b0, mcyc_q, 2'h0, bad_reg_q, busy_q};
            else if (paddr_i == `SDRBT_RSLT_ADDR)
                prdata_o <= {24'h000000, rslt_q};
            else if (paddr_i == `SDRBT_ACC_ADDR)
                prdata_o <= {24'h000000, acc};
            else if (paddr_i == `SDRBT_FLAG_ADDR)
                prdata_o <= {24'h000000, flags_q};
            else if (paddr_i == `SDRBT_CTRL_ADDR)
                prdata_o <= {13'h0000, bsel_q, 1'b0, rsel_q, 2'h0, mode_q, 1'b0, op_q, 3'h0, busy_q};
        end
    end
endmodule // sdrbt_unit
`default_nettype wire

// ==== verif/sdrbt_unit_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdrbt_props
(
    // Clock and reset
    input wire clk_sys_i,
    input wire sys_rst_i,
    // APB
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    // Status
    input wire busy_o,
    input wire done_o,
    input wire [7:0] flags_o,
    input wire [7:0] acc_o
);
    // ****
    // Start decode
    // ****
    // Accepted start of an operation
    wire go = psel_i && penable_i && pwrite_i && paddr_i == 12'h000 && pwdata_i[0] && !busy_o;
    wire [2:0] op = pwdata_i[6:4];
    wire [1:0] md = pwdata_i[9:8];
    // Shift on a real register, not code 110
    wire sh = go && op < 3'h3;
    wire shr = sh && md == 2'h0 && pwdata_i[14:12] != 3'h6;
    wire btr = go && op == 3'h5 && md == 2'h0 && pwdata_i[14:12] != 3'h6;
    wire dig = go && (op == 3'h3 || op == 3'h4);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_done_one_cycle: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
    a_reg_shift_time: assert property (shr |-> ##1 (busy_o && !done_o)[*8] ##1
        (done_o && !flags_o[4] && !flags_o[1])) else $error("register shift timing or flags");
    a_ptr_shift_time: assert property (sh && md == 2'h1 |-> ##16 done_o) else $error("pointer shift timing");
    a_idx_shift_time: assert property (sh && md == 2'h2 |-> ##24 done_o) else $error("indexed shift timing");
    a_dig_acc_high: assert property (dig |-> ##19 (done_o && acc_o[7:4] == $past(acc_o[7:4], 19)))
        else $error("digit rotate timing or high nibble");
    a_dig_flag_set: assert property (dig |-> ##19 (flags_o[0] == $past(flags_o[0], 19) &&
        flags_o[2] == ~^acc_o && flags_o[6] == (acc_o == 8'h00) && flags_o[7] == acc_o[7] &&
        !flags_o[4] && !flags_o[1])) else $error("digit rotate flags");
    a_bit_test_flags: assert property (btr |-> ##9 (done_o &&
        flags_o[4] && !flags_o[1] && flags_o[0] == $past(flags_o[0], 9))) else $error("bit test flags");
    a_lsr_sign_clear: assert property (shr && op == 3'h2 |-> ##9 !flags_o[7]) else $error("sign after lsr");
endmodule // sdrbt_props
bind sdrbt_unit sdrbt_props u_props (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o),
    .done_o(done_o), .flags_o(flags_o), .acc_o(acc_o));
`default_nettype wire

// ==== verif/tb_shift_digit_rotate_bit_test_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_shift_digit_rotate_bit_test_unit;
    // Stimulus and observed signals
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, busy_o, done_o;
    logic [7:0] flags_o, acc_o;
    logic [31:0] rd;
    logic err;
    logic [8:0] r;
    logic [7:0] vals [0:7] = '{8'hB1, 8'h80, 8'h01, 8'h8F, 8'h00, 8'hFF, 8'h00, 8'hB8};
    int fail_count = 0;
    int compares = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    sdrbt_unit dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .busy_o(busy_o),
        .done_o(done_o), .flags_o(flags_o), .acc_o(acc_o));
    // ****
    // Helpers
    // ****
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %0t seen %h want %h", $time, s, e);
        end
    endtask
    task conclude;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task tmo;
        fail_count++;
        $display("ERROR %0t wait ran out", $time);
        conclude;
    endtask
    // One APB transfer, held until pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        @(posedge clk_sys_i);
        while (pready_o !== 1'b1)
        begin
            n++;
            if (n > 20) tmo;
            @(posedge clk_sys_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Start an operation, wait for idle
    task run(input logic [2:0] op, input logic [1:0] md, input logic [2:0] rg, input logic [2:0] b);
        int n;
        n = 0;
        apb(1'b1, 12'h000, {13'h0, b, 1'b0, rg, 2'b0, md, 1'b0, op, 4'h1});
        @(posedge clk_sys_i);
        while (busy_o !== 1'b0)
        begin
            n++;
            if (n > 60) tmo;
            @(posedge clk_sys_i);
        end
    endtask
    // Carry and result of a shift
    function logic [8:0] shf(input logic [2:0] op, input logic [7:0] v);
        case (op)
            3'h0: shf = {v, 1'b0};
            3'h1: shf = {v[0], v[7], v[7:1]};
            default: shf = {v[0], 1'b0, v[7:1]};
        endcase
    endfunction
    // Documented flag bits S Z H PV N C
    function logic [7:0] fl(input logic [8:0] x);
        fl = {x[7], x[7:0] == 8'h00, 3'b000, ~^x[7:0], 1'b0, x[8]};
    endfunction
    // ****
    // Sequence
    // ****
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        chk(flags_o, 8'h00);
        // Every shift on every register code except 110
        for (int op = 0; op < 3; op++)
            for (int c = 0; c < 8; c++)
                if (c != 6)
                begin
                    r = shf(op[2:0], vals[c]);
                    apb(1'b1, {7'h01, c[2:0], 2'b00}, {24'h0, vals[c]});
                    run(op[2:0], 2'h0, c[2:0], 3'h0);
                    apb(1'b0, {7'h01, c[2:0], 2'b00}, 32'h0);
                    chk(rd, {23'h0, r[7:0]});
                    chk(flags_o & 8'hD7, fl(r));
                end
        // Memory operand modes
        for (int m = 1; m < 3; m++)
            for (int op = 0; op < 3; op++)
            begin
                r = shf(op[2:0], 8'h88 + m[7:0]);
                apb(1'b1, 12'h008, {24'h0, 8'h88 + m[7:0]});
                run(op[2:0], m[1:0], 3'h0, 3'h0);
                apb(1'b0, 12'h008, 32'h0);
                chk(rd, {23'h0, r[7:0]});
                chk(flags_o & 8'hD7, fl(r));
                apb(1'b0, 12'h00C, 32'h0);
                chk(rd[12:4], (m == 1) ? {5'd15, 1'b0, 3'd4} : {5'd23, 1'b0, 3'd6});
            end
        // Digit rotates with carry preset
        apb(1'b1, 12'h018, 32'h01);
        apb(1'b1, 12'h03C, 32'h7A);
        apb(1'b1, 12'h008, 32'h31);
        run(3'h3, 2'h0, 3'h0, 3'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h1A);
        chk(acc_o, 8'h73);
        chk(flags_o & 8'hD7, 8'h01);
        apb(1'b1, 12'h03C, 32'h84);
        apb(1'b1, 12'h008, 32'h20);
        run(3'h4, 2'h0, 3'h0, 3'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h42);
        chk(acc_o, 8'h80);
        chk(flags_o & 8'hD7, 8'h81);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h80);
        // Bit test at every position
        apb(1'b1, 12'h024, 32'h5A);
        for (int b = 0; b < 8; b++)
        begin
            run(3'h5, 2'h0, 3'h1, b[2:0]);
            r = {1'b0, 8'h5A >> b};
            chk(flags_o & 8'h53, {1'b0, ~r[0], 6'h11});
        end
        apb(1'b0, 12'h024, 32'h0);
        chk(rd, 32'h5A);
        // Code 110 and an unmapped place
        run(3'h0, 2'h0, 3'h6, 3'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd[1], 1'b1);
        apb(1'b0, 12'h100, 32'h0);
        chk(err, 1'b1);
        conclude;
    end
endmodule // tb_shift_digit_rotate_bit_test_unit
`default_nettype wire
